// file: rtl/pin_mux_pkg.sv
// Package for the pin-function multiplexer: modes, widths, pin positions.
// Assumes a single clock domain and no software-visible registers.
package pin_mux_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int PORT_W = 8;
    localparam int P3_W = 4;
    localparam int NUM_PORTS = 9;
    localparam int NUM_CS = 5;

    // ------------------------------------------------------------
    // Processor modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_EXPAND = 2'h1,
        MODE_MICRO = 2'h3
    } proc_mode_t;

    // ------------------------------------------------------------
    // Pin positions
    // ------------------------------------------------------------
    localparam int P0_ADDR_LO = 6;
    localparam int P0_READY_SAMPLE_STROBE = 5;
    localparam int P3_WEL = 0;
    localparam int P3_WEH = 1;
    localparam int P3_ALE = 2;
    localparam int P3_BUS_GRANT_ACKNOWLEDGE = 3;
    localparam int P4_HOLD = 0;
    localparam int P4_RDY = 1;
    localparam int P4_CLK = 2;
    localparam int P6_TA4_OUT = 0;
    localparam int P6_SUBCLK = 7;
    localparam int P7_UART2_TX = 2;
    localparam int P7_UART2_CLK = 4;
    localparam int P7_SUB_OSCILLATOR_OUTPUT = 6;
    localparam int P8_UART0_TX = 2;
    localparam int P8_UART1_TX = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

endpackage

// file: rtl/port_regs.sv
// Port data and direction registers, one byte each per port.
// Assumes writes arrive as one-cycle strobes from the core side.
module port_regs #(
    parameter int N = 9
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Write side
    input wire logic [N-1:0] data_we,
    input wire logic [N-1:0] dir_we,
    input wire logic [7:0] wdata,
    // Register contents
    output logic [N*8-1:0] data_q,
    output logic [N*8-1:0] dir_q
);
    import pin_mux_pkg::*;

    // ------------------------------------------------------------
    // Per-port storage
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_port
            // Direction clears to input on reset
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    dir_q[g*8 +: 8] <= DIR_RESET;
                    data_q[g*8 +: 8] <= DATA_RESET;
                end else begin
                    if (dir_we[g]) dir_q[g*8 +: 8] <= wdata;
                    if (data_we[g]) data_q[g*8 +: 8] <= wdata;
                end
            end
        end
    endgenerate
endmodule // port_regs

// file: rtl/pin_mux.sv
// Pin-function multiplexer for all multi-purpose port pins.
// Assumes bus and peripheral signals come from internal blocks on clk.
// Notes on behaviour
// - Mode pin low: single/expansion; high: microprocessor
// - Reset input low holds reset state
// - Enable pin: bus status, else read strobe
// - Width pin low 16-bit, high 8-bit
// - Single-chip port 0: eight per-bit-direction pins
// - All port pins inputs after reset; in expansion modes ports 0 and 3 drive from the first clock after reset
// - Expansion port 0: chip selects, ready strobe, A16-A17
// - Port 1: address/high data, or address only
// - Port 2 multiplexes low address and data
// - Port 3: write strobes, latch strobe, hold acknowledge
// - Port 4: hold, ready in; clock out
// - Memory expansion only: P42 may be I/O
// - Port 5: timers A0-A3, key interrupts
// - Port 6: timer A4, interrupts, timer B, subclock
// - Port 7: analog inputs, third UART
// - P76/P77 as sub-oscillator output and input
// - Port 8 carries first and second UART
module pin_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_n,
    // Mode straps
    input wire logic processor_mode_select_pin,
    input wire logic expansion_request,
    input wire logic byte_width_pin,
    input wire logic p42_as_port,
    // Port register writes
    input wire logic [8:0] data_we,
    input wire logic [8:0] dir_we,
    input wire logic [7:0] wdata,
    // Bus side
    input wire logic bus_busy,
    input wire logic bus_read,
    input wire logic bus_addr_phase,
    input wire logic [17:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_drive_data,
    input wire logic [4:0] chip_select_outputs,
    input wire logic ready_sample_strobe,
    input wire logic write_strobe_low_half,
    input wire logic write_strobe_high_half,
    input wire logic addr_latch_strobe,
    input wire logic bus_grant_acknowledge,
    input wire logic bus_clock,
    // Peripheral side
    input wire logic [3:0] timer_a_out,
    input wire logic [3:0] timer_a_out_en,
    input wire logic timer_a4_out,
    input wire logic timer_a4_out_en,
    input wire logic sub_clock,
    input wire logic sub_clock_en,
    input wire logic sub_osc_en,
    input wire logic sub_oscillator_output,
    input wire logic [2:0] uart_en,
    input wire logic [2:0] uart_tx,
    input wire logic [2:0] uart_clk_out,
    input wire logic [2:0] uart_clk_out_en,
    // Pins: inputs, outputs, enables
    input wire logic [71:0] pin_in,
    output logic [71:0] pin_out,
    output logic [71:0] pin_oe,
    output logic enable_pin,
    // Decoded inputs for peripherals and bus
    output logic [15:0] bus_rdata,
    output logic bus_hold_request,
    output logic bus_ready,
    output logic [7:0] timer_a_in,
    output logic [3:0] key_interrupt_inputs,
    output logic [2:0] external_interrupt_inputs,
    output logic [2:0] timer_b_in,
    output logic [7:0] analog_inputs,
    output logic [2:0] uart_rx,
    output logic sub_oscillator_input,
    output logic wide_bus,
    output pin_mux_pkg::proc_mode_t mode
);
    import pin_mux_pkg::*;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic in_reset;
    logic ext_mode;
    logic mem_exp;
    proc_mode_t next_mode;
    assign in_reset = sys_rst | ~reset_n;
    assign next_mode = processor_mode_select_pin ? MODE_MICRO :
                       (expansion_request ? MODE_EXPAND : MODE_SINGLE);
    assign ext_mode = (mode != MODE_SINGLE);
    assign mem_exp = (mode == MODE_EXPAND);

    // Mode is caught while reset is held
    always_ff @(posedge clk) begin
        if (in_reset) begin
            mode <= next_mode;
        end
    end

    // Width sampled in expansion modes only
    always_ff @(posedge clk) begin
        if (in_reset) begin
            wide_bus <= 1'b0;
        end else begin
            wide_bus <= ext_mode & ~byte_width_pin;
        end
    end

    // ------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------
    logic [71:0] data_q;
    logic [71:0] dir_q;
    port_regs #(.N(NUM_PORTS)) i_port_regs (
        .clk(clk),
        .sys_rst(in_reset),
        .data_we(data_we),
        .dir_we(dir_we),
        .wdata(wdata),
        .data_q(data_q),
        .dir_q(dir_q)
    );

    // ------------------------------------------------------------
    // Alternate-function claims: alt_sel, alt_oe, alt_val per pin
    // ------------------------------------------------------------
    logic [71:0] alt_sel;
    logic [71:0] alt_oe;
    logic [71:0] alt_val;
    logic [7:0] p0_alt;
    logic [7:0] p1_alt;
    logic [7:0] p2_alt;
    logic [7:0] p3_alt;
    logic [7:0] p4_val;
    logic [7:0] p4_sel;
    logic [7:0] p4_oe;
    logic clk_on_p42;
    logic [7:0] p5_sel;
    logic [7:0] p6_sel;
    logic [7:0] p7_sel;
    logic [7:0] p7_val;
    logic [7:0] p8_sel;
    logic [7:0] p8_val;

    // Port 0: chip selects, ready strobe, top address bits
    assign p0_alt = {bus_addr[17:16], ready_sample_strobe, chip_select_outputs};
    // Port 1: high address in address phase or on a byte bus, else high data
    assign p1_alt = (bus_addr_phase | ~wide_bus) ? bus_addr[15:8] : bus_wdata[15:8];
    // Port 2: low address, else low data
    assign p2_alt = bus_addr_phase ? bus_addr[7:0] : bus_wdata[7:0];
    // Port 3: strobes and hold acknowledge
    assign p3_alt = {4'h0, bus_grant_acknowledge, addr_latch_strobe,
                     write_strobe_high_half, write_strobe_low_half};
    // Port 4: P40/P41 inputs, P42 clock unless freed in expansion
    assign clk_on_p42 = ext_mode & ~(mem_exp & p42_as_port);
    assign p4_sel = {5'h00, clk_on_p42, ext_mode, ext_mode};
    assign p4_oe = {5'h00, clk_on_p42, 2'h0};
    assign p4_val = {5'h00, bus_clock, 2'h0};
    // Port 5: timer A0-A3 outputs on even pins
    assign p5_sel = {1'b0, timer_a_out_en[3], 1'b0, timer_a_out_en[2],
                     1'b0, timer_a_out_en[1], 1'b0, timer_a_out_en[0]};
    // Port 6: timer A4 out, subclock out on P67
    assign p6_sel = {sub_clock_en, 6'h00, timer_a4_out_en};
    // Port 7: third UART and sub-oscillator
    assign p7_sel = {sub_osc_en, sub_osc_en, 1'b0, uart_clk_out_en[2] & uart_en[2],
                     1'b0, uart_en[2], 2'h0};
    assign p7_val = {1'b0, sub_oscillator_output, 1'b0, uart_clk_out[2],
                     1'b0, uart_tx[2], 2'h0};
    // Port 8: first and second UART
    // Transmit pins kept off the receive pins P81 and P85
    assign p8_sel = {uart_clk_out_en[1] & uart_en[1], uart_en[1], 2'h0,
                     uart_clk_out_en[0] & uart_en[0], uart_en[0], 2'h0};
    assign p8_val = {uart_clk_out[1], uart_tx[1], 2'h0,
                     uart_clk_out[0], uart_tx[0], 2'h0};

    // Whole-pin claim, enable and value vectors (port 0 in low byte)
    assign alt_sel = {p8_sel, p7_sel, p6_sel, p5_sel, p4_sel,
                      {8{ext_mode}}, {8{ext_mode}}, {8{ext_mode}}, {8{ext_mode}}};
    assign alt_oe = {p8_sel, p7_sel & 8'h7f, p6_sel, p5_sel, p4_oe,
                     {4'h0, {4{ext_mode}}},
                     {8{ext_mode & (bus_addr_phase | bus_drive_data)}},
                     {8{ext_mode & (bus_addr_phase | bus_drive_data | ~wide_bus)}},
                     {8{ext_mode}}};
    assign alt_val = {p8_val, p7_val, sub_clock, 6'h00, timer_a4_out,
                      1'b0, timer_a_out[3], 1'b0, timer_a_out[2],
                      1'b0, timer_a_out[1], 1'b0, timer_a_out[0],
                      p4_val, p3_alt, p2_alt, p1_alt, p0_alt};

    // ------------------------------------------------------------
    // Per-pin selection between port registers and alternate function
    // ------------------------------------------------------------
    logic [71:0] next_out;
    logic [71:0] next_oe;
    genvar b;
    generate
        for (b = 0; b < 72; b++) begin : g_pin
            // Port 3 upper pins do not exist
            if (b >= 28 && b < 32) begin : g_none
                assign next_out[b] = 1'b0;
                assign next_oe[b] = 1'b0;
            end else begin : g_real
                assign next_out[b] = alt_sel[b] ? alt_val[b] : data_q[b];
                assign next_oe[b] = alt_sel[b] ? alt_oe[b] : dir_q[b];
            end
        end
    endgenerate

    // Registered pin drivers; all inputs during reset
    always_ff @(posedge clk) begin
        if (in_reset) begin
            pin_out <= 72'h0;
            pin_oe <= 72'h0;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
        end
    end

    // Enable pin: access status, or read strobe in expansion modes
    always_ff @(posedge clk) begin
        if (in_reset) begin
            enable_pin <= 1'b1;
        end else if (ext_mode) begin
            enable_pin <= ~bus_read;
        end else begin
            enable_pin <= ~bus_busy;
        end
    end

    // ------------------------------------------------------------
    // Input routing to bus and peripherals
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (in_reset) begin
            bus_rdata <= 16'h0000;
            bus_hold_request <= 1'b0;
            bus_ready <= 1'b1;
        end else begin
            bus_rdata <= {wide_bus ? pin_in[15:8] : 8'h00, pin_in[23:16]};
            bus_hold_request <= ext_mode & ~pin_in[32 + P4_HOLD];
            bus_ready <= ~ext_mode | pin_in[32 + P4_RDY];
        end
    end

    // Peripheral inputs
    always_ff @(posedge clk) begin
        if (in_reset) begin
            timer_a_in <= 8'h00;
            key_interrupt_inputs <= 4'hf;
            external_interrupt_inputs <= 3'h7;
            timer_b_in <= 3'h0;
            analog_inputs <= 8'h00;
            uart_rx <= 3'h7;
            sub_oscillator_input <= 1'b0;
        end else begin
            timer_a_in <= pin_in[47:40];
            key_interrupt_inputs <= pin_in[47:44];
            timer_b_in <= pin_in[55:53];
            external_interrupt_inputs <= pin_in[52:50];
            analog_inputs <= pin_in[63:56];
            uart_rx <= {pin_in[59], pin_in[69], pin_in[65]};
            sub_oscillator_input <= sub_osc_en & pin_in[63];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_inputs: assert property (@(posedge clk)
        $past(in_reset) |-> pin_oe == 72'h0)
        else $error("Pins not inputs after reset");
    a_mode_micro: assert property (@(posedge clk)
        in_reset && processor_mode_select_pin |=> mode == MODE_MICRO)
        else $error("Mode pin high did not select microprocessor mode");
    a_reset_hold: assert property (@(posedge clk)
        !reset_n |=> pin_oe == 72'h0 && enable_pin)
        else $error("Reset input low did not hold reset");
    a_p0_cs_drive: assert property (@(posedge clk) disable iff (in_reset)
        ext_mode && !$past(in_reset) |=> pin_oe[4:0] == 5'h1f)
        else $error("Chip selects not driven");
    a_p42_free: assert property (@(posedge clk) disable iff (in_reset)
        mode == MODE_MICRO |-> ##1 (pin_oe[34] || $past(in_reset)))
        else $error("Clock output freed in microprocessor mode");
    a_enable_read: assert property (@(posedge clk) disable iff (in_reset)
        ext_mode && bus_read |=> !enable_pin)
        else $error("Read strobe not asserted");
    a_single_dir: assert property (@(posedge clk) disable iff (in_reset)
        mode == MODE_SINGLE |=> pin_oe[7:0] == $past(dir_q[7:0]))
        else $error("Port 0 direction not from register");
    a_wel_out: assert property (@(posedge clk) disable iff (in_reset)
        ext_mode |=> pin_out[24] == $past(write_strobe_low_half))
        else $error("Low write strobe not on port 3");
    a_width: assert property (@(posedge clk) disable iff (in_reset)
        ext_mode && byte_width_pin |=> !wide_bus)
        else $error("Byte pin high did not select 8-bit bus");
endmodule // pin_mux

// file: tb/ext_bus_model.sv
// Far-side model: memory on the expansion bus, plus hold and ready sources.
// Assumes the mux registers its pins on clk and the read strobe is active low.
module ext_bus_model (
    // Clock
    input wire logic clk,
    // Device pins
    input wire logic [71:0] pin_out,
    input wire logic [71:0] pin_oe,
    input wire logic enable_pin,
    // Scenario controls
    input wire logic want_hold,
    input wire logic stall,
    // Lines back to the device
    output logic [15:0] data_lines,
    output logic hold_n,
    output logic ready_line
);
    logic [15:0] addr = 16'h0000;
    logic [15:0] last = 16'h0000;

    // Latch the address under the latch strobe, remember what was driven
    always @(posedge clk) begin
        if (pin_oe[26] && pin_out[26]) begin
            addr <= {pin_out[15:8], pin_out[23:16]};
        end
        if (!enable_pin) begin
            last <= data_lines;
        end
    end

    // Data only under the read strobe; released lines never keep the old value
    assign data_lines = !enable_pin ? addr ^ 16'h5a3c : ~last;
    // Hold request is active low; ready drops while a stall is commanded
    assign hold_n = !want_hold;
    assign ready_line = !stall;
endmodule // ext_bus_model

// file: tb/tb_pin_mux.sv
// Self-checking bench for the pin-function multiplexer.
// Assumes pin_mux_pkg, pin_mux and ext_bus_model are compiled before it.
module tb_pin_mux;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_mux_pkg::*;

    // ----------------
    // Signals
    // ----------------
    logic clk = 1'b0, sys_rst = 1'b1, reset_n = 1'b1;
    logic processor_mode_select_pin = 1'b0, expansion_request = 1'b0;
    logic byte_width_pin = 1'b0, p42_as_port = 1'b0;
    logic [8:0] data_we = 9'h000, dir_we = 9'h000;
    logic [7:0] wdata = 8'h00;
    logic bus_busy = 1'b0, bus_read = 1'b0, bus_addr_phase = 1'b0, bus_drive_data = 1'b0;
    logic [17:0] bus_addr = 18'h00000;
    logic [15:0] bus_wdata = 16'h0000;
    logic [4:0] chip_select_outputs = 5'h1f;
    logic ready_sample_strobe = 1'b0, write_strobe_low_half = 1'b1;
    logic write_strobe_high_half = 1'b1, addr_latch_strobe = 1'b0;
    logic bus_grant_acknowledge = 1'b0, bus_clock = 1'b0;
    logic [3:0] timer_a_out = 4'h0, timer_a_out_en = 4'h0;
    logic timer_a4_out = 1'b0, timer_a4_out_en = 1'b0, sub_clock = 1'b0;
    logic sub_clock_en = 1'b0, sub_osc_en = 1'b0, sub_oscillator_output = 1'b0;
    logic [2:0] uart_en = 3'h0, uart_tx = 3'h0, uart_clk_out = 3'h0, uart_clk_out_en = 3'h0;
    logic [71:0] ext = 72'h0, pin_in, pin_out, pin_oe;
    logic [15:0] bus_rdata, data_lines;
    logic [7:0] timer_a_in, analog_inputs;
    logic [3:0] key_interrupt_inputs;
    logic [2:0] external_interrupt_inputs, timer_b_in, uart_rx;
    logic enable_pin, bus_hold_request, bus_ready, sub_oscillator_input, wide_bus;
    logic hold_n, ready_line, want_hold = 1'b0, stall = 1'b0;
    proc_mode_t mode;
    int miscompares = 0, checked = 0;

    // Each pin shows the device where it drives, else the far side
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {ext[71:34], ready_line, hold_n,
        ext[31:24], data_lines[7:0], data_lines[15:8], ext[7:0]});
    // Clock, 8 ns period
    initial forever #4 clk = ~clk;

    pin_mux i_pin_mux (.*);
    ext_bus_model i_ext_bus_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .enable_pin(enable_pin), .want_hold(want_hold), .stall(stall),
        .data_lines(data_lines), .hold_n(hold_n), .ready_line(ready_line));

    // ----------------
    // Tasks
    // ----------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk_vec(input string what, input logic [71:0] exp, input logic [71:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset(input logic mp, input logic er, input int n);
        processor_mode_select_pin = mp;
        expansion_request = er;
        sys_rst = 1'b1;
        tick(n);
        sys_rst = 1'b0;
        tick(1);
    endtask

    // Port 0 as plain I/O, device reset pin, straps outside reset
    task automatic sc_single_chip;
        chk_vec("mode", {70'h0, MODE_SINGLE}, {70'h0, mode});
        chk_vec("oe", 72'h0, pin_oe);
        wdata = 8'h0f;
        dir_we = 9'h001;
        tick(1);
        dir_we = 9'h000;
        wdata = 8'ha5;
        data_we = 9'h001;
        tick(1);
        data_we = 9'h000;
        bus_busy = 1'b1;
        tick(1);
        chk_vec("p0", {56'h0, 8'h0f, 8'ha5}, {56'h0, pin_oe[7:0], pin_out[7:0]});
        chk_vec("enable", 72'h0, {71'h0, enable_pin});
        bus_busy = 1'b0;
        processor_mode_select_pin = 1'b1;
        reset_n = 1'b0;
        tick(2);
        chk_vec("oe held", 72'h0, pin_oe);
        chk_vec("enable held", 72'h1, {71'h0, enable_pin});
        reset_n = 1'b1;
        processor_mode_select_pin = 1'b0;
        tick(2);
        chk_vec("strap", {70'h0, MODE_MICRO}, {70'h0, mode});
        do_reset(1'b0, 1'b0, 2);
        chk_vec("oe again", 72'h0, pin_oe);
    endtask

    // Inputs decoded from ports 5 to 8
    task automatic sc_inputs(input logic [7:0] v);
        uart_en = 3'h7;
        sub_osc_en = 1'b1;
        uart_tx = {v[2], 2'b00};
        sub_oscillator_output = v[6];
        ext[71:40] = {4{v}};
        tick(2);
        chk_vec("keys", {68'h0, v[7:4]}, {68'h0, key_interrupt_inputs});
        chk_vec("ints", {69'h0, v[4:2]}, {69'h0, external_interrupt_inputs});
        chk_vec("timer b", {69'h0, v[7:5]}, {69'h0, timer_b_in});
        chk_vec("analog", {64'h0, v}, {64'h0, analog_inputs});
        chk_vec("timer a in", {64'h0, v}, {64'h0, timer_a_in});
        chk_vec("rx", {69'h0, v[3], v[5], v[1]}, {69'h0, uart_rx});
        chk_vec("sub_oscillator_input", {71'h0, v[7]}, {71'h0, sub_oscillator_input});
    endtask

    // Peripheral outputs take pins whose direction bits say input
    task automatic sc_alt_out(input logic [9:0] val);
        int pos[10] = '{40, 42, 44, 46, 48, 55, 58, 62, 66, 70};
        logic [1:0] e;
        logic [1:0] g;
        timer_a_out_en = 4'hf;
        timer_a_out = val[3:0];
        timer_a4_out_en = 1'b1;
        timer_a4_out = val[4];
        sub_clock_en = 1'b1;
        sub_clock = val[5];
        uart_tx = {val[6], val[9], val[8]};
        sub_oscillator_output = val[7];
        tick(1);
        for (int i = 0; i < 10; i++) begin
            e = {val[i], 1'b1};
            g = {pin_out[pos[i]], pin_oe[pos[i]]};
            chk_vec("alt", {70'h0, e}, {70'h0, g});
        end
    endtask

    // Address, read and write phases, hold, ready and the clock pin
    task automatic sc_bus(input logic mp, input logic er, input logic bw);
        logic [71:0] e;
        logic [15:0] m;
        int n;
        byte_width_pin = bw;
        do_reset(mp, er, 2);
        e = {70'h0, mp ? MODE_MICRO : MODE_EXPAND};
        chk_vec("mode", e, {70'h0, mode});
        chk_vec("wide", {71'h0, !bw}, {71'h0, wide_bus});
        bus_addr = mp ? 18'h2a5c3 : 18'h1935a;
        chip_select_outputs = 5'h1a;
        ready_sample_strobe = 1'b1;
        addr_latch_strobe = 1'b1;
        write_strobe_low_half = 1'b0;
        bus_grant_acknowledge = 1'b1;
        bus_clock = 1'b1;
        bus_busy = 1'b1;
        bus_addr_phase = 1'b1;
        tick(1);
        chk_vec("p0", {64'h0, bus_addr[17:16], 6'h3a}, {64'h0, pin_out[7:0]});
        chk_vec("addr", {56'h0, bus_addr[15:0]}, {56'h0, pin_out[15:8], pin_out[23:16]});
        chk_vec("oe", {48'h0, 24'hffffff}, {48'h0, pin_oe[23:0]});
        chk_vec("p3", {64'h0, 8'hfe}, {64'h0, pin_oe[27:24], pin_out[27:24]});
        chk_vec("clk pin", 72'h3, {70'h0, pin_oe[34], pin_out[34]});
        m = bus_addr[15:0] ^ 16'h5a3c;
        addr_latch_strobe = 1'b0;
        bus_addr_phase = 1'b0;
        bus_read = 1'b1;
        tick(1);
        e = {55'h0, 1'b0, bw ? 16'hff00 : 16'h0000};
        chk_vec("read", e, {55'h0, enable_pin, pin_oe[15:8], pin_oe[23:16]});
        tick(1);
        e = bw ? {64'h0, m[7:0]} : {56'h0, m};
        chk_vec("rdata", e, {56'h0, bus_rdata});
        bus_read = 1'b0;
        bus_drive_data = 1'b1;
        bus_wdata = 16'h81e7;
        tick(1);
        e = {55'h0, 1'b1, bw ? {bus_addr[15:8], 8'he7} : 16'h81e7};
        chk_vec("write", e, {55'h0, enable_pin, pin_out[15:8], pin_out[23:16]});
        want_hold = 1'b1;
        stall = 1'b1;
        tick(1);
        e = {68'h0, 4'h8};
        chk_vec("hold", e, {68'h0, bus_hold_request, bus_ready, pin_oe[33:32]});
        want_hold = 1'b0;
        stall = 1'b0;
        n = 0;
        while (n < 8 && bus_ready !== 1'b1) begin
            tick(1);
            n++;
        end
        chk_vec("ready", 72'h1, {71'h0, bus_ready});
        if (n == 8) begin
            end_sim;
        end
        p42_as_port = 1'b1;
        tick(1);
        chk_vec("p42", {71'h0, mp || !er}, {71'h0, pin_oe[34]});
        p42_as_port = 1'b0;
        bus_busy = 1'b0;
        bus_drive_data = 1'b0;
    endtask

    // ----------------
    // Main sequence and watchdog
    // ----------------
    initial begin
        do_reset(1'b0, 1'b0, 20);
        sc_single_chip;
        sc_inputs(8'h5a);
        sc_inputs(8'ha5);
        sc_alt_out(10'h3f5);
        sc_alt_out(10'h00a);
        for (int i = 0; i < 4; i++) begin
            sc_bus(i[1], !i[1], i[0]);
        end
        end_sim;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("unexpected run length: expected end, seen timeout");
        end_sim;
    end
endmodule // tb_pin_mux
